// [rtl/gpm_pkg.sv]
/*
  gpm_pkg: constants and carrier types shared by the graphics power-state
  and indirect register window block.
  Assumes a single 250 MHz clock and a synchronous active-low reset.
*/
// What this block does
// [RQ1] power state field bits 1:0, D0/D3
// [RQ2] unsupported state writes are silently discarded
// [RQ3] optional reset pulse on D3 to D0
// [RQ4] bit 15 reads as zero always
// [RQ5] bit 8 reads as zero always
// [RQ6] smi register shared storage, two addresses
// [RQ7] 32-bit scratch register, no hardware effect
// [RQ8] full dword index write loads offset
// [RQ9] index bits 31:2 select dword register
// [RQ10] index read returns held offset
// [RQ11] narrow index writes complete, no update
// [RQ12] dword data write forwarded to target
// [RQ13] dword data read forwarded, value returned
// [RQ14] narrow data reads complete normally
// [RQ15] host avoids narrow data port writes
// [RQ16] host avoids vga registers through window
// [RQ17] window reaches same registers as memory
// [RQ18] reserved bits read zero, ignore writes
`default_nettype none

package gpm_pkg;

  // configuration offsets
  localparam logic [7:0]  CFG_PM_CTRL_STATUS = 8'hd4;
  localparam logic [7:0]  CFG_SMI_TRIGGER    = 8'he0;
  localparam logic [7:0]  CFG_SCRATCH        = 8'hfc;
  // i/o offsets from graphics_io_base
  localparam logic [2:0]  IO_INDEX           = 3'h0;
  localparam logic [2:0]  IO_DATA            = 3'h4;

  // power-state field
  localparam int          PS_LSB             = 0;
  localparam int          PS_MSB             = 1;
  localparam logic [1:0]  PS_D0              = 2'h0;
  localparam logic [1:0]  PS_D1              = 2'h1;
  localparam logic [1:0]  PS_D2              = 2'h2;
  localparam logic [1:0]  PS_D3              = 2'h3;
  localparam int          WAKE_FLAG_BIT      = 15;
  localparam int          WAKE_ALLOW_BIT     = 8;

  // index field
  localparam int          IDX_LSB            = 2;
  localparam logic [31:0] IDX_WMASK          = 32'hfffffffc;

  // reset values
  localparam logic [1:0]  PS_RESET           = 2'h0;
  localparam logic [15:0] SMI_RESET          = 16'h0000;
  localparam logic [31:0] SCRATCH_RESET      = 32'h00000000;
  localparam logic [31:0] INDEX_RESET        = 32'h00000000;

  // byte enables of a full dword
  localparam logic [3:0]  BE_FULL            = 4'hf;

  // cycle of a configuration or i/o request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } gpm_req_t;

  // answer to the host
  typedef struct packed {
    logic        done;
    logic [31:0] rdata;
  } gpm_rsp_t;

  // forwarded access to graphics register space
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [29:0] dw_addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } gpm_mmio_req_t;

endpackage

`default_nettype wire

// [rtl/gpm_pm_state.sv]
/*
  gpm_pm_state: power-state holder of the graphics function.
  Assumes writes come as a one-cycle strobe on the block clock.
*/
`default_nettype none

module gpm_pm_state (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_state,
  input  wire logic       reinit_en,
  output logic      [1:0] state,
  output logic            reinit
);

  logic [1:0] state_q;
  logic       reinit_q;
  logic       legal;

  assign legal = (wr_state == gpm_pkg::PS_D0) ||
                 (wr_state == gpm_pkg::PS_D3); // RQ2

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= gpm_pkg::PS_RESET;
    end else if (wr_en && legal) begin
      state_q <= wr_state; // RQ1
    end
  end

  // one-cycle pulse so downstream logic may reinitialise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reinit_q <= 1'b0;
    end else begin
      reinit_q <= reinit_en && wr_en && legal &&
                  (state_q == gpm_pkg::PS_D3) &&
                  (wr_state == gpm_pkg::PS_D0); // RQ3
    end
  end

  assign state  = state_q;
  assign reinit = reinit_q;

endmodule

`default_nettype wire

// [rtl/gpm_index_window.sv]
/*
  gpm_index_window: index/data pair giving indirect access to graphics
  register space.
  Assumes one request per cycle, answered the next cycle unless the
  forwarded read is still outstanding.
*/
`default_nettype none

module gpm_index_window (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire gpm_pkg::gpm_req_t     io_req,
  output gpm_pkg::gpm_rsp_t          io_rsp,
  output gpm_pkg::gpm_mmio_req_t     mmio_req,
  input  wire logic                  mmio_done,
  input  wire logic [31:0]           mmio_rdata,
  output logic                       busy
);

  typedef enum logic [1:0] {GPM_IDLE, GPM_WAIT, GPM_ANSWER} gpm_win_t;

  gpm_win_t               st_q;
  logic [31:0]            index_q;
  gpm_pkg::gpm_rsp_t      rsp_q;
  gpm_pkg::gpm_mmio_req_t fwd_q;
  logic                   take;
  logic                   is_idx;
  logic                   is_dat;
  logic                   busy_q;

  assign take   = io_req.valid && (st_q == GPM_IDLE);
  assign is_idx = io_req.addr[2:0] == gpm_pkg::IO_INDEX;
  assign is_dat = io_req.addr[2:0] == gpm_pkg::IO_DATA;

  // only a full dword write moves the offset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      index_q <= gpm_pkg::INDEX_RESET;
    end else if (take && io_req.write && is_idx &&
                 io_req.be == gpm_pkg::BE_FULL) begin // RQ8 RQ11
      index_q <= io_req.wdata & gpm_pkg::IDX_WMASK; // RQ9 RQ18
    end
  end

  // narrow data writes still forwarded with their lanes; host avoids them
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fwd_q <= '0;
    end else begin
      fwd_q.valid <= take && is_dat; // RQ12 RQ13 RQ14 RQ15
      fwd_q.write <= io_req.write;
      fwd_q.dw_addr <= index_q[31:gpm_pkg::IDX_LSB]; // RQ9 RQ17
      fwd_q.be <= io_req.be;
      fwd_q.wdata <= io_req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q   <= GPM_IDLE;
      rsp_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      rsp_q.done <= 1'b0;
      case (st_q)
        GPM_IDLE: begin
          if (take && is_dat && !io_req.write) begin
            st_q   <= GPM_WAIT;
            busy_q <= 1'b1; // RQ13
          end else if (take) begin
            rsp_q.done  <= 1'b1;
            rsp_q.rdata <= (is_idx && !io_req.write) ? index_q
                                                     : 32'h00000000; // RQ10
          end
        end
        GPM_WAIT: begin
          if (mmio_done) begin
            st_q <= GPM_ANSWER;
            rsp_q.rdata <= mmio_rdata; // RQ13
          end
        end
        GPM_ANSWER: begin
          rsp_q.done <= 1'b1;
          st_q <= GPM_IDLE;
          busy_q <= 1'b0;
        end
        default: begin
          st_q <= GPM_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  assign io_rsp   = rsp_q;
  assign mmio_req = fwd_q;
  // kept as its own flop so the top output needs no decode of the state
  assign busy     = busy_q;

endmodule

`default_nettype wire

// [rtl/gpm_func1_regs.sv]
/*
  gpm_func1_regs: configuration registers of the second graphics function
  (power state, shared smi register, scratch store) plus the i/o window.
  Assumes the host bridge presents decoded configuration and i/o requests
  as one-cycle strobes on the block clock and waits for the done pulse.
  Function 0 shares the smi storage through its own request port.
*/
`default_nettype none

module gpm_func1_regs (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire gpm_pkg::gpm_req_t      cfg_req,
  output gpm_pkg::gpm_rsp_t           cfg_rsp,
  input  wire gpm_pkg::gpm_req_t      f0_smi_req,
  output gpm_pkg::gpm_rsp_t           f0_smi_rsp,
  input  wire gpm_pkg::gpm_req_t      io_req,
  output gpm_pkg::gpm_rsp_t           io_rsp,
  output gpm_pkg::gpm_mmio_req_t      mmio_req,
  input  wire logic                   mmio_done,
  input  wire logic [31:0]            mmio_rdata,
  input  wire logic                   reinit_enable,
  output logic      [1:0]             power_state,
  output logic                        gfx_reinit,
  output logic                        io_busy
);

  gpm_pkg::gpm_rsp_t cfg_rsp_q;
  gpm_pkg::gpm_rsp_t f0_rsp_q;
  logic [15:0]       smi_q;
  logic [31:0]       scratch_q;
  logic [1:0]        power_state_q;
  logic              ps_wr;
  logic [1:0]        ps_now;
  logic              reinit_w;
  logic [31:0]       pm_word;
  logic [15:0]       smi_next;

  assign ps_wr = cfg_req.valid && cfg_req.write && cfg_req.be[0] &&
                 cfg_req.addr == gpm_pkg::CFG_PM_CTRL_STATUS;

  gpm_pm_state u_pm (
    .clock     (clock),
    .rst_n     (rst_n),
    .wr_en     (ps_wr),
    .wr_state  (cfg_req.wdata[gpm_pkg::PS_MSB:gpm_pkg::PS_LSB]),
    .reinit_en (reinit_enable),
    .state     (ps_now),
    .reinit    (reinit_w)
  );

  // wake bits tied low, reserved bits zero
  always_comb begin
    pm_word = 32'h00000000;
    pm_word[gpm_pkg::PS_MSB:gpm_pkg::PS_LSB] = ps_now; // RQ1
    pm_word[gpm_pkg::WAKE_FLAG_BIT]  = 1'b0; // RQ4
    pm_word[gpm_pkg::WAKE_ALLOW_BIT] = 1'b0; // RQ5 RQ18
  end

  // one storage, two ports; function 1 wins when both write in a cycle
  always_comb begin
    smi_next = smi_q;
    if (f0_smi_req.valid && f0_smi_req.write &&
        f0_smi_req.addr == gpm_pkg::CFG_SMI_TRIGGER) begin
      if (f0_smi_req.be[0]) smi_next[7:0]  = f0_smi_req.wdata[7:0];
      if (f0_smi_req.be[1]) smi_next[15:8] = f0_smi_req.wdata[15:8];
    end
    if (cfg_req.valid && cfg_req.write &&
        cfg_req.addr == gpm_pkg::CFG_SMI_TRIGGER) begin
      if (cfg_req.be[0]) smi_next[7:0]  = cfg_req.wdata[7:0];
      if (cfg_req.be[1]) smi_next[15:8] = cfg_req.wdata[15:8];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      smi_q <= gpm_pkg::SMI_RESET;
    end else begin
      smi_q <= smi_next; // RQ6
    end
  end

  // scratch bytes written per lane; only the config read path reads them
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_scratch
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          scratch_q[8*b +: 8] <= gpm_pkg::SCRATCH_RESET[8*b +: 8];
        end else if (cfg_req.valid && cfg_req.write && cfg_req.be[b] &&
                     cfg_req.addr == gpm_pkg::CFG_SCRATCH) begin
          scratch_q[8*b +: 8] <= cfg_req.wdata[8*b +: 8]; // RQ7
        end
      end
    end
  endgenerate

  // read data reflects state before a same-cycle write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_rsp_q <= '0;
    end else begin
      cfg_rsp_q.done <= cfg_req.valid; // RQ2
      if (cfg_req.valid) begin
        case (cfg_req.addr)
          gpm_pkg::CFG_PM_CTRL_STATUS: cfg_rsp_q.rdata <= pm_word;
          gpm_pkg::CFG_SMI_TRIGGER:    cfg_rsp_q.rdata <= {16'h0000, smi_q};
          gpm_pkg::CFG_SCRATCH:        cfg_rsp_q.rdata <= scratch_q; // RQ7
          default:                     cfg_rsp_q.rdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      f0_rsp_q <= '0;
    end else begin
      f0_rsp_q.done <= f0_smi_req.valid;
      if (f0_smi_req.valid) begin
        f0_rsp_q.rdata <= (f0_smi_req.addr == gpm_pkg::CFG_SMI_TRIGGER) ?
                          {16'h0000, smi_q} : 32'h00000000; // RQ6
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      power_state_q <= gpm_pkg::PS_RESET;
    end else begin
      power_state_q <= ps_now;
    end
  end

  // window answers already come from flip-flops inside it
  gpm_index_window u_win (
    .clock      (clock),
    .rst_n      (rst_n),
    .io_req     (io_req),
    .io_rsp     (io_rsp),
    .mmio_req   (mmio_req),
    .mmio_done  (mmio_done),
    .mmio_rdata (mmio_rdata),
    .busy       (io_busy)
  );

  assign cfg_rsp     = cfg_rsp_q;
  assign f0_smi_rsp  = f0_rsp_q;
  assign power_state = power_state_q;
  assign gfx_reinit  = reinit_w;

endmodule

`default_nettype wire

// [testbench/gpm_func1_properties.sv]
/* gpm_func1_properties: timing and value checks on gpm_func1_regs.
   Assumes it is bound to the block and sees only its ports. */
`default_nettype none
module gpm_func1_properties (
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire gpm_pkg::gpm_req_t      cfg_req,
  input wire gpm_pkg::gpm_rsp_t      cfg_rsp,
  input wire gpm_pkg::gpm_req_t      f0_smi_req,
  input wire gpm_pkg::gpm_rsp_t      f0_smi_rsp,
  input wire gpm_pkg::gpm_req_t      io_req,
  input wire gpm_pkg::gpm_rsp_t      io_rsp,
  input wire gpm_pkg::gpm_mmio_req_t mmio_req,
  input wire logic                   mmio_done,
  input wire logic [31:0]            mmio_rdata,
  input wire logic                   reinit_enable,
  input wire logic [1:0]             power_state,
  input wire logic                   gfx_reinit,
  input wire logic                   io_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic pm_wr;
  logic io_go;
  assign pm_wr = cfg_req.valid && cfg_req.write && cfg_req.be[0]
    && cfg_req.addr == gpm_pkg::CFG_PM_CTRL_STATUS;
  // requests made while busy are dropped by contract
  assign io_go = io_req.valid && !io_busy;
  a_cfg_answer: assert property (
    cfg_req.valid |=> cfg_rsp.done) else $error("config answer late");
  a_cfg_cause: assert property (
    cfg_rsp.done |-> $past(cfg_req.valid)) else $error("stray done");
  a_pm_ro_bits: assert property (
    cfg_req.valid && !cfg_req.write
    && cfg_req.addr == gpm_pkg::CFG_PM_CTRL_STATUS
    |=> cfg_rsp.rdata[31:2] == 30'h0) else $error("pm fixed bits set");
  a_ps_bad_kept: assert property (
    pm_wr && cfg_req.wdata[0] != cfg_req.wdata[1]
    |=> ##1 $stable(power_state)) else $error("bad state taken");
  a_ps_good_load: assert property (
    pm_wr && cfg_req.wdata[0] == cfg_req.wdata[1]
    |=> ##1 power_state == $past(cfg_req.wdata[1:0], 2))
    else $error("state not loaded");
  a_smi_answer: assert property (
    f0_smi_req.valid |=> f0_smi_rsp.done) else $error("f0 answer late");
  a_idx_read: assert property (
    io_go && !io_req.write && io_req.addr[2:0] == gpm_pkg::IO_INDEX
    |=> io_rsp.done && io_rsp.rdata[1:0] == 2'h0)
    else $error("index read wrong");
  a_idx_write: assert property (
    io_go && io_req.write && io_req.addr[2:0] == gpm_pkg::IO_INDEX
    |=> io_rsp.done) else $error("index write late");
  a_data_fwd: assert property (
    io_go && io_req.addr[2:0] == gpm_pkg::IO_DATA
    |=> mmio_req.valid && mmio_req.write == $past(io_req.write))
    else $error("data not forwarded");
  a_rd_return: assert property (
    mmio_done && io_busy |-> ##2 io_rsp.done
    && io_rsp.rdata == $past(mmio_rdata, 2)) else $error("bad read data");
  a_busy_on_read: assert property (
    mmio_req.valid && !mmio_req.write |-> io_busy)
    else $error("busy low in read");
  a_busy_done: assert property (
    io_rsp.done |-> !io_busy) else $error("busy at answer");
  c_reinit: cover property (gfx_reinit);
  c_slow_rd: cover property (mmio_req.valid ##5 mmio_done);
  c_in_d3: cover property (power_state == gpm_pkg::PS_D3);
endmodule
`default_nettype wire

// [testbench/gpm_gfx_space_model.sv]
/* gpm_gfx_space_model: graphics register space behind the window.
   Assumes forwarded strobes; answers reads promptly and slowly in turn. */
`default_nettype none
module gpm_gfx_space_model (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire gpm_pkg::gpm_mmio_req_t mmio_req,
  output logic                        mmio_done,
  output logic [31:0]                 mmio_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [256];
  logic [31:0] last_q;
  logic [7:0]  rd_dw_q;
  logic [1:0]  wait_q;
  logic        pend_q;
  logic        slow_q;
  logic        done_q;
  assign mmio_done = done_q;
  // off the answer cycle show the inverse, never a stale copy
  assign mmio_rdata = done_q ? last_q : ~last_q;
  always_ff @(posedge clock) begin
    done_q <= 1'b0;
    if (!rst_n) begin
      pend_q <= 1'b0;
      slow_q <= 1'b0;
      last_q <= 32'h00000000;
    end else if (mmio_req.valid && mmio_req.write) begin
      for (int i = 0; i < 4; i++) begin
        if (mmio_req.be[i]) begin
          mem[mmio_req.dw_addr[7:0]][8*i +: 8] <= mmio_req.wdata[8*i +: 8];
        end
      end
    end else if (mmio_req.valid) begin
      pend_q  <= 1'b1;
      rd_dw_q <= mmio_req.dw_addr[7:0];
      wait_q  <= slow_q ? 2'h3 : 2'h0;
      slow_q  <= ~slow_q;
    end else if (pend_q) begin
      if (wait_q == 2'h0) begin
        done_q <= 1'b1;
        last_q <= mem[rd_dw_q];
        pend_q <= 1'b0;
      end else begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/tb.sv]
/* tb: sequences of config and i/o accesses with expected values.
   Assumes the block, its checker and the register space model. */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   clock = 1'b0;
  logic                   rst_n = 1'b0;
  gpm_pkg::gpm_req_t      cfg_req, f0_smi_req, io_req;
  gpm_pkg::gpm_rsp_t      cfg_rsp, f0_smi_rsp, io_rsp;
  gpm_pkg::gpm_mmio_req_t mmio_req;
  logic                   mmio_done, reinit_enable, gfx_reinit, io_busy;
  logic [31:0]            mmio_rdata, r, last_dw;
  logic [1:0]             power_state;
  int                     fail_count = 0, checked = 0, reinits = 0;
  always #2 clock = ~clock;
  always @(posedge clock) begin
    if (gfx_reinit === 1'b1) reinits++;
    if (mmio_req.valid === 1'b1) last_dw = {2'h0, mmio_req.dw_addr};
  end
  gpm_func1_regs gpm_func1_regs_inst (.clock, .rst_n, .cfg_req, .cfg_rsp,
    .f0_smi_req, .f0_smi_rsp, .io_req, .io_rsp, .mmio_req, .mmio_done,
    .mmio_rdata, .reinit_enable, .power_state, .gfx_reinit, .io_busy);
  gpm_gfx_space_model gpm_gfx_space_model_inst (.clock, .rst_n,
    .mmio_req, .mmio_done, .mmio_rdata);
  task automatic complete_run;
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // p: 0 function-1 config, 1 function-0 smi port, 2 i/o
  task automatic acc(input int p, input logic w, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    gpm_pkg::gpm_rsp_t s;
    int n;
    if (p == 0) cfg_req = {1'b1, w, a, be, d};
    else if (p == 1) f0_smi_req = {1'b1, w, a, be, d};
    else io_req = {1'b1, w, a, be, d};
    @(posedge clock);
    #1;
    cfg_req = '0;
    f0_smi_req = '0;
    io_req = '0;
    for (n = 0; n < 40; n++) begin
      s = p == 0 ? cfg_rsp : p == 1 ? f0_smi_rsp : io_rsp;
      if (s.done === 1'b1) break;
      @(posedge clock);
      #1;
    end
    if (n == 40) chk("done", 32'h1, 32'h0);
    r = s.rdata;
    // idle edge so no request line is assigned twice in one step
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input int p, input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] e, input string nm);
    acc(p, 1'b0, a, be, 32'h0);
    chk(nm, e, r);
  endtask
  initial begin
    cfg_req = '0;
    f0_smi_req = '0;
    io_req = '0;
    reinit_enable = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    rd(0, 8'hd4, 4'hf, 32'h0, "pm reset");
    rd(0, 8'he0, 4'hf, 32'h0, "smi reset");
    rd(0, 8'hfc, 4'hf, 32'h0, "scratch reset");
    rd(2, 8'h00, 4'hf, 32'h0, "index reset");
    acc(0, 1'b1, 8'hd4, 4'hf, 32'hffffffff);
    rd(0, 8'hd4, 4'hf, 32'h3, "pm fields");
    chk("state", 32'h3, {30'h0, power_state});
    for (int i = 1; i < 3; i++) begin
      acc(0, 1'b1, 8'hd4, 4'hf, 32'(i));
      rd(0, 8'hd4, 4'hf, 32'h3, "pm kept");
    end
    acc(0, 1'b1, 8'hd4, 4'hf, 32'h0);
    reinit_enable = 1'b0;
    acc(0, 1'b1, 8'hd4, 4'hf, 32'h3);
    acc(0, 1'b1, 8'hd4, 4'hf, 32'h0);
    rd(0, 8'hd4, 4'hf, 32'h0, "pm d0");
    chk("reinits", 32'h1, reinits);
    acc(0, 1'b1, 8'he0, 4'hf, 32'ha5c3);
    rd(1, 8'he0, 4'hf, 32'ha5c3, "smi f0");
    acc(1, 1'b1, 8'he0, 4'hf, 32'h1234);
    rd(0, 8'he0, 4'hf, 32'h1234, "smi f1");
    acc(0, 1'b1, 8'hfc, 4'hf, 32'hdeadbeef);
    rd(0, 8'hfc, 4'hf, 32'hdeadbeef, "scratch");
    rd(0, 8'h40, 4'hf, 32'h0, "unmapped");
    acc(2, 1'b1, 8'h00, 4'hf, 32'h104);
    rd(2, 8'h00, 4'hf, 32'h104, "index");
    acc(2, 1'b1, 8'h00, 4'h3, 32'hffff);
    acc(2, 1'b1, 8'h00, 4'h1, 32'hff);
    rd(2, 8'h00, 4'hf, 32'h104, "index narrow");
    acc(2, 1'b1, 8'h00, 4'hf, 32'h107);
    rd(2, 8'h00, 4'hf, 32'h104, "index low");
    // host keeps to dword data writes and no vga registers
    acc(2, 1'b1, 8'h04, 4'hf, 32'hcafef00d);
    chk("dw addr", 32'h41, last_dw);
    acc(2, 1'b1, 8'h00, 4'hf, 32'h200);
    acc(2, 1'b1, 8'h04, 4'hf, 32'h0badcafe);
    rd(2, 8'h04, 4'hf, 32'h0badcafe, "data 80");
    acc(2, 1'b1, 8'h00, 4'hf, 32'h104);
    rd(2, 8'h04, 4'hf, 32'hcafef00d, "data 41");
    rd(2, 8'h04, 4'h3, 32'hcafef00d, "data narrow");
    complete_run;
  end
  initial begin
    #20000;
    fail_count++;
    complete_run;
  end
endmodule
bind gpm_func1_regs gpm_func1_properties gpm_func1_properties_inst (
  .clock, .rst_n, .cfg_req, .cfg_rsp, .f0_smi_req, .f0_smi_rsp, .io_req,
  .io_rsp, .mmio_req, .mmio_done, .mmio_rdata, .reinit_enable,
  .power_state, .gfx_reinit, .io_busy);
`default_nettype wire
